//--- angle_cond_pkg.sv
/*
 * Shared constants of the angle conditioning pipeline: register byte
 * offsets, field positions, reset values and driver mode codes.
 * Assumes a 32-bit APB register bus and 16-bit angle words.
 */
package angle_cond_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] LOOP_CFG_OFS = 8'h00;
    localparam logic [7:0] SENS_COEF_OFS = 8'h04;
    localparam logic [7:0] ORTH_COEF_OFS = 8'h08;
    localparam logic [7:0] EQ_GAIN_OFS = 8'h0C;
    localparam logic [7:0] ZERO_OFS_OFS = 8'h10;
    localparam logic [7:0] COMP_CTRL_OFS = 8'h14;
    localparam logic [7:0] DELAY_TRIM_OFS = 8'h18;
    localparam logic [7:0] ENDPT1_OFS = 8'h1C;
    localparam logic [7:0] ENDPT2_OFS = 8'h20;
    localparam logic [7:0] FAULT_BAND_OFS = 8'h24;
    localparam logic [7:0] PIN_CFG_OFS = 8'h28;
    localparam logic [7:0] CORR_I_OFS = 8'h2C;
    localparam logic [7:0] CORR_Q_OFS = 8'h30;
    localparam logic [7:0] COND_OUT_OFS = 8'h34;
    localparam logic [7:0] EQ_BASE_OFS = 8'h40;
    localparam logic [7:0] EQ_LAST_OFS = 8'h7C;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int LFC_LO_POS = 8;
    localparam int LFC_HI_POS = 11;
    localparam int OS_POS = 14;
    localparam int COMP_DIS_POS = 5;
    localparam int GPIO_MODE_POS = 9;
    localparam int INC_MODE_POS = 14;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] SENS_COEF_RST = 16'h8000;
    localparam logic [15:0] ORTH_COEF_RST = 16'h0000;
    localparam logic [15:0] ENDPT_RST = 16'h0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // Coefficient scale 2^15
    localparam int COEF_SHIFT = 15;
    // Delay in 1/64 of an update period per count
    localparam int DELAY_SHIFT = 6;
    localparam int EQ_FRAC_BITS = 12;
    // ---------------------------------------------------------------
    // Driver modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DRV_HIZ = 2'h0,
        DRV_OD_P = 2'h1,
        DRV_OD_N = 2'h2,
        DRV_PUSH_PULL = 2'h3
    } drv_mode_t;
endpackage

//--- angle_linearizer.sv
/*
 * Sixteen-point angular linearization with gain scaling, one register
 * stage. Assumes the point table is held by the caller and packed
 * with point 0 in the low byte.
 */
`timescale 1ns/1ps
`default_nettype none
module angle_linearizer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [15:0] in_angle,
    input wire logic [127:0] points,
    input wire logic [2:0] gain,
    output logic out_valid,
    output logic [15:0] out_angle
);
    import angle_cond_pkg::*;

    logic [3:0] idx;
    logic [3:0] idx_next;
    logic [11:0] frac;
    logic signed [7:0] p0;
    logic signed [7:0] p1;
    logic signed [21:0] interp;
    logic signed [31:0] scaled;
    logic [15:0] corr;

    // -----------------------------------------------------------------
    // Interpolation between neighbouring points, wrapping at a full turn
    // -----------------------------------------------------------------
    always_comb begin
        idx = in_angle[15:12];
        idx_next = idx + 4'h1;
        frac = in_angle[11:0];
        p0 = points[idx*8 +: 8];
        p1 = points[idx_next*8 +: 8];
        interp = 22'(p0 * $signed(23'h1000)) + 22'((p1 - p0) * $signed({1'b0, frac}));
        // One point count is 2^(gain-1) angle steps
        scaled = (32'(interp) <<< gain) >>> (EQ_FRAC_BITS + 1);
        corr = (gain == 3'h0) ? 16'h0000 : scaled[15:0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_angle <= 16'h0000;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_angle <= in_angle + corr;
            end
        end
    end

    gain_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && gain == 3'h0 |=> out_angle == $past(in_angle))
        else $error("linearization applied with zero gain");
endmodule
`default_nettype wire

//--- angle_conditioning_pipeline.sv
/*
 * Angle post-processing datapath with its APB register file: I/Q
 * correction, linearization, zero offset, latency compensation and
 * output conditioning, plus loop filter, input filter and driver setup.
 * Assumes the tracking loop outside supplies phase and speed words,
 * speed in angle steps per update period, all synchronous to CLOCK.
 */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module angle_conditioning_pipeline #(
    parameter int INTERNAL_DELAY = 64
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic IQ_VALID,
    input wire logic signed [15:0] I_IN,
    input wire logic signed [15:0] Q_IN,
    output logic signed [15:0] CORR_I,
    output logic signed [15:0] CORR_Q,
    input wire logic PHASE_VALID,
    input wire logic [15:0] PHASE_IN,
    input wire logic signed [15:0] SPEED_IN,
    input wire logic SAFE_STATE,
    output logic ANGLE_VALID,
    output logic [15:0] ANGLE_OUT,
    output logic [2:0] LFC_LOW,
    output logic [2:0] LFC_HIGH,
    output logic ADAPT_EN,
    output logic [1:0] OVERSHOOT,
    output logic [2:0] FILTER_EN,
    input wire logic GPIO_DATA,
    input wire logic [2:0] INC_DATA,
    output logic GPIO_O,
    output logic GPIO_OE,
    output logic [2:0] INC_O,
    output logic [2:0] INC_OE
);
    import angle_cond_pkg::*;

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    logic [2:0] lfc_lo_q;
    logic [2:0] lfc_hi_q;
    logic [1:0] os_q;
    logic [15:0] sens_q;
    logic [15:0] orth_q;
    logic [2:0] eq_gain_q;
    logic [7:0] eq_q [16];
    logic [15:0] zofs_q;
    logic comp_dis_q;
    logic [7:0] trim_q;
    logic [15:0] y1_q;
    logic [15:0] y2_q;
    logic [15:0] fault_q;
    logic [2:0] filt_q;
    drv_mode_t gpio_mode_q;
    drv_mode_t inc_mode_q;
    logic [127:0] eq_flat;

    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [31:0] rd_d;

    // Drives a pin according to its mode; used for the GPIO pin and the three INC pins
    function automatic logic [1:0] drive(input drv_mode_t m, input logic d);
        case (m)
            DRV_OD_P: drive = {d, d};
            DRV_OD_N: drive = {d, ~d};
            DRV_PUSH_PULL: drive = {d, 1'b1};
            default: drive = 2'b00;
        endcase
    endfunction

    function automatic logic signed [16:0] smin(input logic signed [16:0] a,
                                                input logic signed [16:0] b);
        smin = (a < b) ? a : b;
    endfunction

    assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_setup = PSEL && !PENABLE;

    always_comb begin
        for (int k = 0; k < 16; k++) begin
            eq_flat[k*8 +: 8] = eq_q[k];
        end
    end

    // -----------------------------------------------------------------
    // Read decode
    // -----------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_d = UNMAPPED_DATA;
        case (PADDR)
            LOOP_CFG_OFS: rd_d = 32'({os_q, lfc_hi_q, lfc_lo_q} << LFC_LO_POS);
            SENS_COEF_OFS: rd_d = 32'(sens_q);
            ORTH_COEF_OFS: rd_d = 32'(orth_q);
            EQ_GAIN_OFS: rd_d = 32'(eq_gain_q);
            ZERO_OFS_OFS: rd_d = 32'(zofs_q);
            COMP_CTRL_OFS: rd_d = 32'(comp_dis_q) << COMP_DIS_POS;
            DELAY_TRIM_OFS: rd_d = 32'(trim_q);
            ENDPT1_OFS: rd_d = 32'(y1_q);
            ENDPT2_OFS: rd_d = 32'(y2_q);
            FAULT_BAND_OFS: rd_d = 32'(fault_q);
            PIN_CFG_OFS: rd_d = (32'(inc_mode_q) << INC_MODE_POS)
                | (32'(gpio_mode_q) << GPIO_MODE_POS) | 32'(filt_q);
            CORR_I_OFS: rd_d = 32'(CORR_I);
            CORR_Q_OFS: rd_d = 32'(CORR_Q);
            COND_OUT_OFS: rd_d = 32'(ANGLE_OUT);
            default: begin
                if (PADDR >= EQ_BASE_OFS && PADDR <= EQ_LAST_OFS && PADDR[1:0] == 2'h0) begin
                    rd_d = 32'(eq_q[PADDR[5:2]]);
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // -----------------------------------------------------------------
    // APB answer: one wait-free access phase after every setup
    // -----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= rd_setup;
            PSLVERR <= rd_setup && !mapped;
            if (rd_setup && !PWRITE) begin
                PRDATA <= rd_d;
            end
        end
    end

    // -----------------------------------------------------------------
    // Register writes
    // -----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            lfc_lo_q <= 3'h0;
            lfc_hi_q <= 3'h0;
            os_q <= 2'h0;
            sens_q <= SENS_COEF_RST;
            orth_q <= ORTH_COEF_RST;
            eq_gain_q <= 3'h0;
            zofs_q <= 16'h0000;
            comp_dis_q <= 1'b0;
            trim_q <= 8'h00;
            y1_q <= ENDPT_RST;
            y2_q <= ENDPT_RST;
            fault_q <= 16'h0000;
            filt_q <= 3'h0;
            gpio_mode_q <= DRV_HIZ;
            inc_mode_q <= DRV_HIZ;
            for (int k = 0; k < 16; k++) begin
                eq_q[k] <= 8'h00;
            end
        end else if (wr_en) begin
            case (PADDR)
                LOOP_CFG_OFS: begin
                    lfc_lo_q <= PWDATA[LFC_LO_POS +: 3];
                    lfc_hi_q <= PWDATA[LFC_HI_POS +: 3];
                    os_q <= PWDATA[OS_POS +: 2];
                end
                SENS_COEF_OFS: sens_q <= PWDATA[15:0];
                ORTH_COEF_OFS: orth_q <= PWDATA[15:0];
                EQ_GAIN_OFS: eq_gain_q <= PWDATA[2:0];
                ZERO_OFS_OFS: zofs_q <= PWDATA[15:0];
                COMP_CTRL_OFS: comp_dis_q <= PWDATA[COMP_DIS_POS];
                DELAY_TRIM_OFS: trim_q <= PWDATA[7:0];
                ENDPT1_OFS: y1_q <= PWDATA[15:0];
                ENDPT2_OFS: y2_q <= PWDATA[15:0];
                FAULT_BAND_OFS: fault_q <= PWDATA[15:0];
                PIN_CFG_OFS: begin
                    filt_q <= PWDATA[2:0];
                    gpio_mode_q <= drv_mode_t'(PWDATA[GPIO_MODE_POS +: 2]);
                    inc_mode_q <= drv_mode_t'(PWDATA[INC_MODE_POS +: 2]);
                end
                default: begin
                    // Values outside -127..127 are stored as written
                    if (PADDR >= EQ_BASE_OFS && PADDR <= EQ_LAST_OFS) begin
                        eq_q[PADDR[5:2]] <= PWDATA[7:0];
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Loop filter and pin setup towards the tracking loop and pads
    // -----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            LFC_LOW <= 3'h0;
            LFC_HIGH <= 3'h0;
            ADAPT_EN <= 1'b0;
            OVERSHOOT <= 2'h0;
            FILTER_EN <= 3'h0;
        end else begin
            // Codes index a cutoff table doubling per step
            LFC_LOW <= lfc_lo_q;
            LFC_HIGH <= lfc_hi_q;
            ADAPT_EN <= (lfc_lo_q != lfc_hi_q);
            OVERSHOOT <= os_q;
            FILTER_EN <= filt_q;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            GPIO_O <= 1'b0;
            GPIO_OE <= 1'b0;
            INC_O <= 3'h0;
            INC_OE <= 3'h0;
        end else begin
            {GPIO_O, GPIO_OE} <= drive(gpio_mode_q, GPIO_DATA);
            for (int k = 0; k < 3; k++) begin
                {INC_O[k], INC_OE[k]} <= drive(inc_mode_q, INC_DATA[k]);
            end
        end
    end

    // -----------------------------------------------------------------
    // Sensitivity and orthogonality correction
    // -----------------------------------------------------------------
    logic signed [31:0] iq_cross;
    logic signed [31:0] qq_scale;
    always_comb begin
        iq_cross = (Q_IN * $signed(orth_q)) >>> COEF_SHIFT;
        // Sensitivity is unsigned so that 0x8000 means unity gain
        qq_scale = (Q_IN * $signed({1'b0, sens_q})) >>> COEF_SHIFT;
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            CORR_I <= 16'sh0000;
            CORR_Q <= 16'sh0000;
        end else if (IQ_VALID) begin
            CORR_I <= I_IN + iq_cross[15:0];
            CORR_Q <= qq_scale[15:0];
        end
    end

    // -----------------------------------------------------------------
    // Linearization, zero offset and latency compensation
    // -----------------------------------------------------------------
    logic lin_valid;
    logic [15:0] lin_angle;
    logic signed [15:0] speed_q;

    angle_linearizer u_lin (
        .clk(CLOCK),
        .rst_n(RSTN),
        .in_valid(PHASE_VALID),
        .in_angle(PHASE_IN),
        .points(eq_flat),
        .gain(eq_gain_q),
        .out_valid(lin_valid),
        .out_angle(lin_angle)
    );

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            speed_q <= 16'sh0000;
        end else if (PHASE_VALID) begin
            speed_q <= SPEED_IN;
        end
    end

    logic signed [31:0] comp_full;
    logic [15:0] comp;
    always_comb begin
        // Internal plus trim delay, in 1/64 update periods
        comp_full = (speed_q * $signed({1'b0, 15'(INTERNAL_DELAY) + 15'(trim_q)})) >>> DELAY_SHIFT;
        comp = comp_dis_q ? 16'h0000 : comp_full[15:0];
    end

    logic adj_valid;
    logic [15:0] adj_angle;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            adj_valid <= 1'b0;
            adj_angle <= 16'h0000;
        end else begin
            adj_valid <= lin_valid;
            if (lin_valid) begin
                adj_angle <= lin_angle + zofs_q + comp;
            end
        end
    end

    // -----------------------------------------------------------------
    // Output conditioning
    // -----------------------------------------------------------------
    logic bypass;
    logic invert;
    logic signed [16:0] lo;
    logic signed [16:0] hi;
    logic [16:0] span;
    logic [32:0] prod;
    logic signed [17:0] shaped;
    logic signed [17:0] clamped;
    always_comb begin
        bypass = (y1_q == 16'h0000) && (y2_q == 16'h0000 || y2_q == 16'hFFFF);
        invert = $signed(y1_q) > $signed(y2_q);
        lo = smin($signed({y1_q[15], y1_q}), $signed({y2_q[15], y2_q}));
        hi = lo == $signed({y1_q[15], y1_q}) ? $signed({y2_q[15], y2_q})
                                              : $signed({y1_q[15], y1_q});
        span = 17'(hi - lo);
        // Full turn maps onto the span; output step is span/65536 per angle step
        prod = 33'(adj_angle) * 33'(span);
        if (invert) begin
            shaped = $signed({y1_q[15], y1_q[15], y1_q}) - $signed({1'b0, prod[32:16]});
        end else begin
            shaped = $signed({y1_q[15], y1_q[15], y1_q}) + $signed({1'b0, prod[32:16]});
        end
        if (shaped < 18'(lo)) begin
            clamped = 18'(lo);
        end else if (shaped > 18'(hi)) begin
            clamped = 18'(hi);
        end else begin
            clamped = shaped;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ANGLE_VALID <= 1'b0;
            ANGLE_OUT <= 16'h0000;
        end else begin
            ANGLE_VALID <= adj_valid;
            if (SAFE_STATE) begin
                ANGLE_OUT <= fault_q;
            end else if (adj_valid) begin
                ANGLE_OUT <= bypass ? adj_angle : clamped[15:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    adapt_enable_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        lfc_lo_q == lfc_hi_q |=> !ADAPT_EN)
        else $error("adaptation left on with equal limits");

    overshoot_out_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        ##1 OVERSHOOT == $past(os_q))
        else $error("overshoot code not passed on");

    corr_quad_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        IQ_VALID |=> CORR_Q == $past(qq_scale[15:0]) && CORR_I == $past(I_IN + iq_cross[15:0]))
        else $error("I/Q correction wrong");

    comp_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        lin_valid && comp_dis_q |=> adj_angle == $past(lin_angle + zofs_q))
        else $error("compensation applied while disabled");

    bypass_path_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        adj_valid && bypass && !SAFE_STATE |=> ANGLE_OUT == $past(adj_angle))
        else $error("bypass not honoured");

    clamp_range_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        adj_valid && !bypass && !SAFE_STATE |=> $signed({ANGLE_OUT[15], ANGLE_OUT}) >= $past(lo)
            && $signed({ANGLE_OUT[15], ANGLE_OUT}) <= $past(hi))
        else $error("output outside endpoint range");

    fault_band_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        SAFE_STATE |=> ANGLE_OUT == $past(fault_q))
        else $error("fault band value not sent");

    hiz_pin_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        gpio_mode_q == DRV_HIZ |=> !GPIO_OE)
        else $error("pin driven in high impedance mode");

    push_pull_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        inc_mode_q == DRV_PUSH_PULL |=> INC_OE == 3'h7 && INC_O == $past(INC_DATA))
        else $error("push-pull pins not driven");
endmodule
`default_nettype wire

//--- tracking_model.sv
/*
 * Stand-in for the tracking loop and I/Q front end feeding the pipeline.
 * Assumes its tasks are called by the bench right after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tracking_model (
    input wire logic CLOCK,
    output logic PHASE_VALID,
    output logic [15:0] PHASE_IN,
    output logic signed [15:0] SPEED_IN,
    output logic IQ_VALID,
    output logic signed [15:0] I_IN,
    output logic signed [15:0] Q_IN
);
    initial begin
        PHASE_VALID = 1'b0;
        IQ_VALID = 1'b0;
        PHASE_IN = 16'h0000;
        SPEED_IN = 16'sh0000;
        I_IN = 16'sh0000;
        Q_IN = 16'sh0000;
    end
    // Words are inverted once taken, so a stale word never passes for a fresh one
    task automatic phase(input logic [15:0] p, input logic signed [15:0] s);
        @(posedge CLOCK);
        PHASE_VALID <= 1'b1;
        PHASE_IN <= p;
        SPEED_IN <= s;
        @(posedge CLOCK);
        PHASE_VALID <= 1'b0;
        PHASE_IN <= ~p;
        SPEED_IN <= ~s;
    endtask
    task automatic iq(input logic signed [15:0] i, input logic signed [15:0] q);
        @(posedge CLOCK);
        IQ_VALID <= 1'b1;
        I_IN <= i;
        Q_IN <= q;
        @(posedge CLOCK);
        IQ_VALID <= 1'b0;
        I_IN <= ~i;
        Q_IN <= ~q;
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
/*
 * Self-checking bench of the angle conditioning pipeline over APB.
 * Assumes tracking_model stands in for the tracking loop.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import angle_cond_pkg::*;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic SAFE_STATE = 1'b0;
    logic GPIO_DATA = 1'b1;
    logic [2:0] INC_DATA = 3'h5;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, IQ_VALID, PHASE_VALID, ANGLE_VALID, ADAPT_EN, GPIO_O, GPIO_OE;
    logic signed [15:0] I_IN, Q_IN, CORR_I, CORR_Q, SPEED_IN;
    logic [15:0] PHASE_IN, ANGLE_OUT;
    logic [2:0] LFC_LOW, LFC_HIGH, FILTER_EN, INC_O, INC_OE;
    logic [1:0] OVERSHOOT;
    logic [31:0] rd_data;
    logic slv_err;
    int mismatches = 0;
    int comparisons = 0;
    logic [2:0] inc_oe_exp [4] = '{3'h0, 3'h5, 3'h2, 3'h7};

    always #2 CLOCK = ~CLOCK;

    angle_conditioning_pipeline #(.INTERNAL_DELAY(64)) angle_conditioning_pipeline_inst (.*);
    tracking_model tracking_model_inst (.*);

    task automatic results();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // Ready is looked at mid-cycle, where it has settled
        do begin
            @(negedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            results();
        end
        rd_data = PRDATA;
        slv_err = PSLVERR;
        @(posedge CLOCK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge CLOCK);
    endtask
    // Speed is always 16, so each sample's own speed and compensation are known
    task automatic angle(input logic [15:0] p, input logic [15:0] exp);
        int n;
        n = 0;
        tracking_model_inst.phase(p, 16'sd16);
        do begin
            @(negedge CLOCK);
            n++;
        end while (ANGLE_VALID !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            results();
        end
        chk(ANGLE_OUT, exp);
    endtask

    initial begin
        repeat (4) @(posedge CLOCK);
        RSTN <= 1'b1;
        apb(1'b0, SENS_COEF_OFS, 32'h0);
        chk(rd_data, 32'h0000_8000);
        apb(1'b0, 8'h3C, 32'h0);
        chk(rd_data, 32'h0);
        chk(slv_err, 32'h1);
        for (int os = 0; os < 4; os++) begin
            apb(1'b1, LOOP_CFG_OFS, (os << OS_POS) | (3 << LFC_HI_POS) | (1 << LFC_LO_POS));
            settle();
            chk(OVERSHOOT, os);
            chk({ADAPT_EN, LFC_HIGH, LFC_LOW}, 32'h59);
        end
        apb(1'b1, LOOP_CFG_OFS, 32'h1200);
        settle();
        chk({ADAPT_EN, LFC_HIGH, LFC_LOW}, 32'h12);
        $display("Loop filter test done");
        tracking_model_inst.iq(16'sd1000, 16'sd2000);
        settle();
        chk(CORR_Q, 32'sd2000);
        apb(1'b1, ORTH_COEF_OFS, 32'h4000);
        apb(1'b1, SENS_COEF_OFS, 32'h4000);
        tracking_model_inst.iq(16'sd1000, 16'sd2000);
        settle();
        chk(CORR_I, 32'sd2000);
        chk(CORR_Q, 32'sd1000);
        $display("IQ correction test done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, PIN_CFG_OFS, (m << INC_MODE_POS) | (m << GPIO_MODE_POS) | 5);
            settle();
            chk(FILTER_EN, 32'h5);
            chk({GPIO_OE, INC_OE}, {m[0], inc_oe_exp[m]});
            chk({GPIO_O, INC_O}, (m == 0) ? 32'h0 : 32'hD);
        end
        $display("Pin setup test done");
        apb(1'b1, COMP_CTRL_OFS, 32'h20);
        apb(1'b1, ZERO_OFS_OFS, 32'h1000);
        angle(16'h2000, 16'h3000);
        apb(1'b1, EQ_BASE_OFS, 32'h01);
        apb(1'b1, EQ_BASE_OFS + 8'h04, 32'h11);
        for (int g = 0; g < 8; g++) begin
            apb(1'b1, EQ_GAIN_OFS, g);
            angle(16'h0000, 16'h1000 + ((g == 0) ? 16'h0 : 16'(1 << (g - 1))));
        end
        apb(1'b1, EQ_GAIN_OFS, 32'h1);
        angle(16'h0800, 16'h1809);
        apb(1'b1, EQ_GAIN_OFS, 32'h0);
        apb(1'b1, COMP_CTRL_OFS, 32'h0);
        angle(16'h2000, 16'h3010);
        apb(1'b1, DELAY_TRIM_OFS, 32'h40);
        angle(16'h2000, 16'h3020);
        $display("Angle path test done");
        apb(1'b1, COMP_CTRL_OFS, 32'h20);
        apb(1'b1, ZERO_OFS_OFS, 32'h0);
        apb(1'b1, ENDPT1_OFS, 32'h1000);
        apb(1'b1, ENDPT2_OFS, 32'h2000);
        angle(16'h4000, 16'h1400);
        apb(1'b1, ENDPT1_OFS, 32'h2000);
        apb(1'b1, ENDPT2_OFS, 32'h1000);
        angle(16'h4000, 16'h1C00);
        apb(1'b1, FAULT_BAND_OFS, 32'hABCD);
        SAFE_STATE <= 1'b1;
        repeat (2) settle();
        chk(ANGLE_OUT, 32'hABCD);
        $display("Conditioning test done");
        results();
    end
endmodule
`default_nettype wire
